/* hdl/rcl_consts.svh */
`ifndef RCL_CONSTS_SVH
`define RCL_CONSTS_SVH
`define RCL_OFS_LOW_SP_HI 8'h08
`define RCL_OFS_LOW_SP_LO 8'h14
`define RCL_OFS_CRIT 8'h19
`define RCL_OFS_HYST 8'h21
`define RCL_OFS_FILT 8'hBF
`define RCL_RST_LOW_SP_HI 8'h00
`define RCL_RST_LOW_SP_LO 3'h0
`define RCL_RST_CRIT 8'h6E
`define RCL_RST_HYST 7'h0A
`define RCL_RST_FILT 3'h0
`define RCL_LOCK_BIT 1
`define RCL_USF_BIT 3
`endif

/* hdl/rcl_pkg.sv */
package rcl_pkg;
   typedef enum logic [1:0] {RCL_FILT_OFF, RCL_FILT_MIN, RCL_FILT_MAX} rcl_filt_e;
endpackage : rcl_pkg

/* hdl/rcl_top.sv */
// How it works
// - Remote low setpoint is a high byte plus three low bits, signed format.
// - Low-bits register holds setpoint bits 7:5, reset to zero.
// - Critical limit is eight bits, resets to 0x6E (110 degrees).
// - Clearing unlock bit then writing a limit locks the critical limit.
// - Limit is compared signed or unsigned per the unsigned-format select.
// - In signed format bit 7 is sign, bits 6:0 weigh 64 down to 1.
// - Temperature above limit sets critical alarm, alert and critical output.
// - Critical output holds until temperature drops below limit minus hysteresis.
// - Hysteresis is bits 6:0, resets to 0x0A.
// - Hysteresis bit 7 is ignored; any value written is accepted.
// - Filter select 00 off, 01/10 minimal, 11 maximum; resets 00.
// - Comparator select 0 latches alert; 1 makes alert follow the condition.
// - Filter register bits 5:3 read back as zero.
`include "rcl_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module rcl_top (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Register port
   input wire logic wr_en,
   input wire logic [7:0] addr,
   input wire logic [7:0] wr_data,
   output logic [7:0] rd_data,
   // Configuration and status
   input wire logic [7:0] config_reg,
   input wire logic [7:0] enh_config_reg,
   input wire logic alarm_read,
   // Temperature input, integer degrees in current format
   input wire logic [7:0] remote_temp,
   // Outputs
   output logic [7:0] low_setpoint,
   output logic [2:0] low_setpoint_low_bits,
   output rcl_pkg::rcl_filt_e remote_filter_mode,
   output logic remote_critical_alarm,
   output logic critical_output,
   output logic alert_n
);
   logic [7:0] lsp_hi_r, lsp_hi_nxt;
   logic [2:0] lsp_lo_r, lsp_lo_nxt;
   logic [7:0] crit_r, crit_nxt;
   logic [6:0] hyst_r, hyst_nxt;
   logic [2:0] filt_r, filt_nxt;
   logic lock_r, lock_nxt;
   logic alarm_r, alarm_nxt;
   logic crit_out_r, crit_out_nxt;
   logic alert_r, alert_nxt;
   logic [7:0] rd_r, rd_nxt;
   rcl_pkg::rcl_filt_e fmode_r, fmode_nxt;
   logic unsigned_format_select;
   logic above;
   logic below_rel;
   logic [8:0] rel;
   logic [7:0] rel8;

   // Signed compare by flipping the sign bit into offset binary
   assign unsigned_format_select = enh_config_reg[`RCL_USF_BIT];
   assign above = unsigned_format_select ? (remote_temp > crit_r)
      : ((remote_temp ^ 8'h80) > (crit_r ^ 8'h80));
   // Release point saturates at the bottom of the range instead of wrapping
   always_comb
   begin
      rel = unsigned_format_select ? ({1'b0, crit_r} - {2'h0, hyst_r})
         : ({1'b0, crit_r ^ 8'h80} - {2'h0, hyst_r});
      rel8 = rel[8] ? 8'h00 : rel[7:0];
   end
   assign below_rel = unsigned_format_select ? (remote_temp < rel8)
      : ((remote_temp ^ 8'h80) < rel8);

   always_comb
   begin
      lsp_hi_nxt = lsp_hi_r;
      lsp_lo_nxt = lsp_lo_r;
      crit_nxt = crit_r;
      hyst_nxt = hyst_r;
      filt_nxt = filt_r;
      lock_nxt = lock_r;
      if (wr_en)
      begin
         unique case (addr)
            `RCL_OFS_LOW_SP_HI: lsp_hi_nxt = wr_data;
            `RCL_OFS_LOW_SP_LO: lsp_lo_nxt = wr_data[7:5];
            `RCL_OFS_CRIT:
            begin
               if (!lock_r)
               begin
                  crit_nxt = wr_data;
                  if (!config_reg[`RCL_LOCK_BIT])
                     lock_nxt = 1'b1;
               end
            end
            `RCL_OFS_HYST: hyst_nxt = wr_data[6:0];
            `RCL_OFS_FILT: filt_nxt = wr_data[2:0];
            default: ;
         endcase
      end
   end

   always_comb
   begin
      unique case (filt_r[2:1])
         2'h0: fmode_nxt = rcl_pkg::RCL_FILT_OFF;
         2'h3: fmode_nxt = rcl_pkg::RCL_FILT_MAX;
         default: fmode_nxt = rcl_pkg::RCL_FILT_MIN;
      endcase
   end

   // Status and pins
   always_comb
   begin
      crit_out_nxt = crit_out_r;
      if (above)
         crit_out_nxt = 1'b1;
      else if (below_rel)
         crit_out_nxt = 1'b0;
      // Alarm latches until read; a new event in the read cycle wins
      alarm_nxt = above | (alarm_r & ~alarm_read);
      // Comparator mode follows the condition; normal mode follows the latched alarm
      alert_nxt = filt_r[0] ? above : alarm_nxt;
   end

   always_comb
   begin
      unique case (addr)
         `RCL_OFS_LOW_SP_HI: rd_nxt = lsp_hi_r;
         `RCL_OFS_LOW_SP_LO: rd_nxt = {lsp_lo_r, 5'h00};
         `RCL_OFS_CRIT: rd_nxt = crit_r;
         `RCL_OFS_HYST: rd_nxt = {1'b0, hyst_r};
         `RCL_OFS_FILT: rd_nxt = {5'h00, filt_r};
         default: rd_nxt = 8'h00;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         lsp_hi_r <= `RCL_RST_LOW_SP_HI;
         lsp_lo_r <= `RCL_RST_LOW_SP_LO;
         crit_r <= `RCL_RST_CRIT;
         hyst_r <= `RCL_RST_HYST;
         filt_r <= `RCL_RST_FILT;
         lock_r <= 1'b0;
         alarm_r <= 1'b0;
         crit_out_r <= 1'b0;
         alert_r <= 1'b0;
         rd_r <= 8'h00;
         fmode_r <= rcl_pkg::RCL_FILT_OFF;
      end
      else
      begin
         lsp_hi_r <= lsp_hi_nxt;
         lsp_lo_r <= lsp_lo_nxt;
         crit_r <= crit_nxt;
         hyst_r <= hyst_nxt;
         filt_r <= filt_nxt;
         lock_r <= lock_nxt;
         alarm_r <= alarm_nxt;
         crit_out_r <= crit_out_nxt;
         alert_r <= alert_nxt;
         rd_r <= rd_nxt;
         fmode_r <= fmode_nxt;
      end
   end

   assign rd_data = rd_r;
   assign low_setpoint = lsp_hi_r;
   assign low_setpoint_low_bits = lsp_lo_r;
   assign remote_filter_mode = fmode_r;
   assign remote_critical_alarm = alarm_r;
   assign critical_output = crit_out_r;
   assign alert_n = ~alert_r;

   property p_crit_reset;
      @(posedge clk) $fell(rst) |-> crit_r == 8'h6E && hyst_r == 7'h0A;
   endproperty
   a_crit_reset: assert property (p_crit_reset) else $error("bad reset limits");

   property p_lock_holds;
      @(posedge clk) disable iff (rst) lock_r |=> $stable(crit_r);
   endproperty
   a_lock_holds: assert property (p_lock_holds) else $error("locked limit changed");

   property p_lock_set;
      @(posedge clk) disable iff (rst)
         wr_en && addr == 8'h19 && !config_reg[1] |=> lock_r;
   endproperty
   a_lock_set: assert property (p_lock_set) else $error("lock not set");

   property p_crit_rise;
      @(posedge clk) disable iff (rst) above |=> critical_output && remote_critical_alarm;
   endproperty
   a_crit_rise: assert property (p_crit_rise) else $error("critical not raised");

   property p_crit_hold;
      @(posedge clk) disable iff (rst)
         critical_output && !below_rel |=> critical_output;
   endproperty
   a_crit_hold: assert property (p_crit_hold) else $error("critical released early");

   property p_filt_rd;
      @(posedge clk) disable iff (rst) addr == 8'hBF |=> rd_data[5:3] == 3'h0;
   endproperty
   a_filt_rd: assert property (p_filt_rd) else $error("reserved bits nonzero");

   property p_hyst_rd;
      @(posedge clk) disable iff (rst) addr == 8'h21 |=> rd_data[6:0] == $past(hyst_r);
   endproperty
   a_hyst_rd: assert property (p_hyst_rd) else $error("hysteresis readback");

   property p_cmp_mode;
      @(posedge clk) disable iff (rst) filt_r[0] && !above |=> alert_n;
   endproperty
   a_cmp_mode: assert property (p_cmp_mode) else $error("comparator alert stuck");

   property p_filt_mode;
      @(posedge clk) disable iff (rst) filt_r[2:1] == 2'h3 |=> remote_filter_mode == rcl_pkg::RCL_FILT_MAX;
   endproperty
   a_filt_mode: assert property (p_filt_mode) else $error("filter mode wrong");

   property p_lsp_hi_wr;
      @(posedge clk) disable iff (rst)
         wr_en && addr == `RCL_OFS_LOW_SP_HI |=> low_setpoint == $past(wr_data);
   endproperty
   a_lsp_hi_wr: assert property (p_lsp_hi_wr) else $error("low setpoint byte not stored");

   property p_lsp_lo_wr;
      @(posedge clk) disable iff (rst)
         wr_en && addr == `RCL_OFS_LOW_SP_LO |=> low_setpoint_low_bits == $past(wr_data[7:5]);
   endproperty
   a_lsp_lo_wr: assert property (p_lsp_lo_wr) else $error("low setpoint bits not stored");

   property p_lo_rd;
      @(posedge clk) disable iff (rst)
         addr == `RCL_OFS_LOW_SP_LO |=> rd_data[4:0] == 5'h00;
   endproperty
   a_lo_rd: assert property (p_lo_rd) else $error("low setpoint unused bits nonzero");

   // A limit write, and the one that arms the lock
   sequence s_crit_wr;
      wr_en && addr == `RCL_OFS_CRIT;
   endsequence

   sequence s_lock_wr;
      s_crit_wr ##0 !config_reg[`RCL_LOCK_BIT];
   endsequence

   property p_crit_wr;
      @(posedge clk) disable iff (rst)
         s_crit_wr ##0 !lock_r |=> crit_r == $past(wr_data);
   endproperty
   a_crit_wr: assert property (p_crit_wr) else $error("unlocked limit write lost");

   property p_lock_blocks;
      @(posedge clk) disable iff (rst)
         s_lock_wr ##1 s_crit_wr |=> crit_r == $past(crit_r);
   endproperty
   a_lock_blocks: assert property (p_lock_blocks) else $error("write after lock landed");

   property p_lock_sticky;
      @(posedge clk) disable iff (rst)
         lock_r |=> lock_r;
   endproperty
   a_lock_sticky: assert property (p_lock_sticky) else $error("lock dropped");

   property p_hyst_wr;
      @(posedge clk) disable iff (rst)
         wr_en && addr == `RCL_OFS_HYST |=> hyst_r == $past(wr_data[6:0]);
   endproperty
   a_hyst_wr: assert property (p_hyst_wr) else $error("hysteresis write lost");

   property p_hyst_top;
      @(posedge clk) disable iff (rst)
         addr == `RCL_OFS_HYST |=> !rd_data[7];
   endproperty
   a_hyst_top: assert property (p_hyst_top) else $error("hysteresis top bit read");

   property p_filt_wr;
      @(posedge clk) disable iff (rst)
         wr_en && addr == `RCL_OFS_FILT |=> filt_r == $past(wr_data[2:0]);
   endproperty
   a_filt_wr: assert property (p_filt_wr) else $error("filter write lost");

   property p_fmode_min;
      @(posedge clk) disable iff (rst)
         filt_r[2] ^ filt_r[1] |=> remote_filter_mode == rcl_pkg::RCL_FILT_MIN;
   endproperty
   a_fmode_min: assert property (p_fmode_min) else $error("minimal filter not chosen");

   property p_signed_cmp;
      @(posedge clk) disable iff (rst)
         !enh_config_reg[`RCL_USF_BIT] && remote_temp[7] && !crit_r[7] |-> !above;
   endproperty
   a_signed_cmp: assert property (p_signed_cmp) else $error("negative reading above limit");

   property p_unsigned_cmp;
      @(posedge clk) disable iff (rst)
         enh_config_reg[`RCL_USF_BIT] && remote_temp[7] && !crit_r[7] |-> above;
   endproperty
   a_unsigned_cmp: assert property (p_unsigned_cmp) else $error("unsigned compare wrong");

   property p_crit_release;
      @(posedge clk) disable iff (rst)
         critical_output && below_rel && !above |=> !critical_output;
   endproperty
   a_crit_release: assert property (p_crit_release) else $error("critical not released");

   property p_alarm_hold;
      @(posedge clk) disable iff (rst)
         remote_critical_alarm && !alarm_read |=> remote_critical_alarm;
   endproperty
   a_alarm_hold: assert property (p_alarm_hold) else $error("alarm dropped unread");

   property p_alarm_clear;
      @(posedge clk) disable iff (rst)
         alarm_read && !above |=> !remote_critical_alarm;
   endproperty
   a_alarm_clear: assert property (p_alarm_clear) else $error("alarm not cleared");

   property p_alert_latched;
      @(posedge clk) disable iff (rst)
         !filt_r[0] |=> alert_n == !remote_critical_alarm;
   endproperty
   a_alert_latched: assert property (p_alert_latched) else $error("alert not latched");

   property p_cmp_set;
      @(posedge clk) disable iff (rst)
         filt_r[0] && above |=> !alert_n;
   endproperty
   a_cmp_set: assert property (p_cmp_set) else $error("comparator alert missing");
endmodule : rcl_top
`default_nettype wire

/* bench/rcl_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
module rcl_host_model (
   // Register port
   input wire logic clk,
   output logic wr_en,
   output logic [7:0] addr,
   output logic [7:0] wr_data,
   input wire logic [7:0] rd_data
);
   initial
   begin
      wr_en = 1'b0;
      addr = 8'h00;
      wr_data = 8'h00;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      wr_en <= 1'b1;
      addr <= a;
      wr_data <= (a == 8'hBF) ? (d & 8'h3F) : d;
      @(posedge clk);
      wr_en <= 1'b0;
      // Released data never repeats the last value
      wr_data <= ~d;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      @(posedge clk);
      #1 d = rd_data;
   endtask : rd
endmodule : rcl_host_model
`default_nettype wire

/* bench/rcl_top_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module rcl_top_tb_top;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic alarm_read = 1'b0;
   logic wr_en, alarm, crit, alert_n;
   logic [7:0] addr, wr_data, rd_data, low_sp, v;
   logic [7:0] cfg = 8'h02;
   logic [7:0] enh = 8'h00;
   logic [7:0] temp = 8'h00;
   logic [2:0] low_bits;
   rcl_pkg::rcl_filt_e fmode;
   int fail_count = 0;
   int checks_done = 0;
   int cycles = 0;
   always #5 clk = ~clk;
   rcl_top u_dut (.clk(clk), .rst(rst), .wr_en(wr_en), .addr(addr), .wr_data(wr_data),
      .rd_data(rd_data), .config_reg(cfg), .enh_config_reg(enh), .alarm_read(alarm_read),
      .remote_temp(temp), .low_setpoint(low_sp), .low_setpoint_low_bits(low_bits),
      .remote_filter_mode(fmode), .remote_critical_alarm(alarm), .critical_output(crit),
      .alert_n(alert_n));
   rcl_host_model u_host (.clk(clk), .wr_en(wr_en), .addr(addr), .wr_data(wr_data),
      .rd_data(rd_data));
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : end_of_test
   // Whole run needs under a hundred cycles
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 3000)
      begin
         fail_count++;
         end_of_test();
      end
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         fail_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic rc(input logic [7:0] a, input logic [7:0] e);
      u_host.rd(a, v);
      chk(v, e);
   endtask : rc
   task automatic fl(input logic [2:0] e);
      chk({5'h00, alarm, crit, alert_n}, {5'h00, e});
   endtask : fl
   task automatic dr(input logic [7:0] t, input logic [7:0] e);
      @(posedge clk);
      temp <= t;
      enh <= e;
      @(posedge clk);
      #1;
   endtask : dr
   task automatic ack();
      @(posedge clk);
      alarm_read <= 1'b1;
      @(posedge clk);
      alarm_read <= 1'b0;
      #1;
   endtask : ack
   task automatic t_regs();
      rc(8'h14, 8'h00);
      rc(8'h19, 8'h6E);
      rc(8'h21, 8'h0A);
      rc(8'hBF, 8'h00);
      rc(8'h55, 8'h00);
      u_host.wr(8'h14, 8'hFF);
      u_host.wr(8'h08, 8'h9C);
      rc(8'h14, 8'hE0);
      chk({low_bits, 5'h00}, 8'hE0);
      chk(low_sp, 8'h9C);
      u_host.wr(8'h21, 8'h8A);
      u_host.rd(8'h21, v);
      chk({1'b0, v[6:0]}, 8'h0A);
      u_host.wr(8'hBF, 8'hFF);
      rc(8'hBF, 8'h07);
      for (int i = 0; i < 4; i++)
      begin
         u_host.wr(8'hBF, 8'(i * 2));
         @(posedge clk);
         #1;
         chk({6'h00, fmode}, 8'((i + 1) / 2));
      end
   endtask : t_regs
   task automatic critical_temperature();
      u_host.wr(8'h19, 8'h50);
      rc(8'h19, 8'h50);
      dr(8'h51, 8'h00);
      fl(3'b110);
      dr(8'h46, 8'h00);
      fl(3'b110);
      dr(8'h45, 8'h00);
      fl(3'b100);
      ack();
      fl(3'b001);
      u_host.wr(8'hBF, 8'h01);
      dr(8'h51, 8'h00);
      fl(3'b110);
      dr(8'h30, 8'h00);
      fl(3'b101);
      ack();
      u_host.wr(8'hBF, 8'h00);
      dr(8'h90, 8'h00);
      fl(3'b001);
      dr(8'h90, 8'h08);
      fl(3'b110);
      dr(8'h30, 8'h00);
      ack();
      fl(3'b001);
   endtask : critical_temperature
   task automatic t_lock();
      @(posedge clk);
      cfg <= 8'h00;
      u_host.wr(8'h19, 8'h60);
      u_host.wr(8'h19, 8'h70);
      rc(8'h19, 8'h60);
      @(posedge clk);
      cfg <= 8'h02;
      u_host.wr(8'h19, 8'h70);
      rc(8'h19, 8'h60);
      @(posedge clk);
      rst <= 1'b1;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      rc(8'h19, 8'h6E);
   endtask : t_lock
   initial
   begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      t_regs();
      critical_temperature();
      t_lock();
      end_of_test();
   end
endmodule : rcl_top_tb_top
`default_nettype wire
